// ### rtl/cmpf_consts.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit AHB-Lite register words, 16-bit registers, not all bits implemented
// Notes: definitions only
//
// Summary of operation
// - mask B or its complement feeds AND
// - mask A or its complement feeds AND
// - three-bit field picks the filter sample clock
// - filter enable bit switches filter on/off
// - divider ratio is two to the code
// - bit 15 powers each reference on
// - bit 14 drives reference level onto pin
// - bit 11 picks external or analog supply span
// - first bit 10 picks external input or ladder
// - second bit 10 picks inverting input reference while first bit 10 picks ladder
// - seven-bit code gives n/128 of input
// - unimplemented reference bits ignore writes, read zero
// - AND output, or inverse, gated into OR
// - level select picks suppressed comparator polarity
// - four-bit selectors pick PWM or fault masks
`ifndef CMPF_CONSTS_SVH
`define CMPF_CONSTS_SVH

// ********************************************************
// register offsets (byte addresses)
// ********************************************************
`define CMPF_OFS_MASK_SRC 8'h00
`define CMPF_OFS_MASK_GATE 8'h04
`define CMPF_OFS_FILTER 8'h08
`define CMPF_OFS_REF_ONE 8'h0C
`define CMPF_OFS_REF_TWO 8'h10
`define CMPF_OFS_STATUS 8'h14

// ********************************************************
// implemented bits and reset values
// ********************************************************
`define CMPF_IMPL_MASK_SRC 16'h0FFF
`define CMPF_IMPL_MASK_GATE 16'hBFFF
`define CMPF_IMPL_FILTER 16'h007F
`define CMPF_IMPL_REF 16'hCC7F
`define CMPF_IMPL_REF_NO_PIN 16'h8C7F
`define CMPF_RESET_VALUE 16'h0000

// ********************************************************
// field positions
// ********************************************************
`define CMPF_BIT_LEVEL_SEL 15
`define CMPF_BIT_NAND_TO_OR 7
`define CMPF_BIT_AND_TO_OR 6
`define CMPF_BIT_AND_B_TRUE 3
`define CMPF_BIT_AND_B_INV 2
`define CMPF_BIT_AND_A_TRUE 1
`define CMPF_BIT_AND_A_INV 0
`define CMPF_BIT_FILT_EN 3
`define CMPF_BIT_REF_POWER 15
`define CMPF_BIT_REF_PIN_OE 14
`define CMPF_BIT_REF_SUPPLY 11
`define CMPF_BIT_REF_INPUT 10

// ********************************************************
// timing
// ********************************************************
`define CMPF_FILTER_SAMPLES 3'h3
`define CMPF_CLK_PERIOD_NS 8

`endif

// ### rtl/cmpf_pkg.sv
// Purpose: shared types of the comparator blank/filter block
// Assumes: constants live in cmpf_consts.svh
// Notes: types only
package cmpf_pkg;

  // ********************************************************
  // types
  // ********************************************************
  typedef logic [31:0] word_t; // bus data word
  typedef logic [15:0] half_t; // implemented register width
  typedef logic [6:0] level_t; // reference level code

  // filter sample clock source codes
  typedef enum logic [2:0] {
    SRC_PERIPH = 3'h0,
    SRC_OSC = 3'h1,
    SRC_PWM_SYNC = 3'h2,
    SRC_RESERVED = 3'h3,
    SRC_TIMER2 = 3'h4,
    SRC_TIMER3 = 3'h5,
    SRC_TIMER4 = 3'h6,
    SRC_TIMER5 = 3'h7
  } clk_src_e;

endpackage : cmpf_pkg

// ### rtl/cmpf_filter_core.sv
// Purpose: filter clock divider and digital debounce filter
// Assumes: din and src_tick are already on CLK
// Notes: output is registered, one cycle behind din when off
`timescale 1ns/1ps
`include "cmpf_consts.svh"
module cmpf_filter_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic src_tick,
  input wire logic [2:0] div_code,
  input wire logic din,
  output logic dout
);
  import cmpf_pkg::*;

  logic [6:0] div_cnt_r; // divider count of source ticks
  logic [2:0] run_r; // consecutive samples at a new level
  logic dout_r; // filtered level
  logic smp_tick; // divided sample strobe
  logic [6:0] div_last; // terminal count for the code

  // ********************************************************
  // divider
  // ********************************************************
  assign div_last = 7'((8'h01 << div_code) - 8'h01);
  // at or past the terminal count, so a code lowered mid-count wraps at once
  assign smp_tick = en && src_tick && (div_cnt_r >= div_last);

  // divider cleared while off so sampling restarts cleanly
  always_ff @(posedge clk) begin
    if (!rst_n || !en) begin
      div_cnt_r <= 7'h00;
    end else if (src_tick) begin
      div_cnt_r <= (div_cnt_r >= div_last) ? 7'h00 : 7'(div_cnt_r + 7'h01);
    end
  end

  // ********************************************************
  // debounce
  // ********************************************************
  // a single glitch sample restarts the run, trading delay for noise immunity
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout_r <= 1'b0;
      run_r <= 3'h0;
    end else if (!en) begin
      dout_r <= din;
      run_r <= 3'h0;
    end else if (smp_tick) begin
      if (din == dout_r) begin
        run_r <= 3'h0;
      end else if (run_r == `CMPF_FILTER_SAMPLES - 3'h1) begin
        dout_r <= din;
        run_r <= 3'h0;
      end else begin
        run_r <= 3'(run_r + 3'h1);
      end
    end
  end

  assign dout = dout_r;

  // ********************************************************
  // checks
  // ********************************************************
  AST_PASS_THROUGH: assert property (
    @(posedge clk) disable iff (!rst_n)
    !en |=> dout == $past(din))
    else $error("filter off but output did not follow input");

  AST_DIV_CLEARED: assert property (
    @(posedge clk) disable iff (!rst_n)
    !en |=> div_cnt_r == 7'h00)
    else $error("divider not cleared while filter off");

  AST_DIV_ONE: assert property (
    @(posedge clk) disable iff (!rst_n)
    en && src_tick && div_code == 3'h0 |-> smp_tick)
    else $error("divide 1:1 skipped a sample");

  AST_HOLD_BETWEEN: assert property (
    @(posedge clk) disable iff (!rst_n)
    en && !smp_tick |=> $stable(dout))
    else $error("filtered output moved without a sample");

endmodule : cmpf_filter_core

// ### rtl/comparator_blank_filter_ref_ctrl.sv
// Purpose: comparator blanking, digital filter and reference control
// Assumes: AHB-Lite slave, zero wait states, one CLK domain
// Notes: pins and source clocks are synchronised before use
`timescale 1ns/1ps
`include "cmpf_consts.svh"
module comparator_blank_filter_ref_ctrl #(
  parameter bit REF2_PIN_PRESENT = 1'b1 // small packages have no second ref pin
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire cmpf_pkg::word_t HWDATA,
  input wire logic HREADY,
  output cmpf_pkg::word_t HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic COMP_IN,
  input wire logic [5:0] PWM_IN,
  input wire logic [1:0] FAULT_IN,
  input wire logic OSC_CLOCK,
  input wire logic PWM_SYNC_OUTPUT_ONE,
  input wire logic TIMER2_CLOCK,
  input wire logic TIMER3_CLOCK,
  input wire logic TIMER4_CLOCK,
  input wire logic TIMER5_CLOCK,
  output logic COMP_OUT,
  output logic BLANK_ACTIVE,
  output logic REF1_POWER_ON,
  output logic REF1_PIN_OUTPUT_ENABLE,
  output logic REF1_SUPPLY_SELECT,
  output logic REF1_INPUT_SELECT,
  output cmpf_pkg::level_t REF1_LEVEL_CODE,
  output logic REF2_POWER_ON,
  output logic REF2_PIN_OUTPUT_ENABLE,
  output logic REF2_SUPPLY_SELECT,
  output cmpf_pkg::level_t REF2_LEVEL_CODE,
  output logic INV_INPUT_FROM_REF_TWO
);
  import cmpf_pkg::*;

  // ********************************************************
  // declarations
  // ********************************************************
  localparam half_t REF2_IMPL = REF2_PIN_PRESENT ?
    `CMPF_IMPL_REF : `CMPF_IMPL_REF_NO_PIN; // pin enable absent on small parts

  half_t mask_src_r, mask_src_nxt; // mask source selectors
  half_t gate_r, gate_nxt; // AND/OR gating control
  half_t filt_r, filt_nxt; // filter control
  half_t ref1_r, ref1_nxt; // reference one control
  half_t ref2_r, ref2_nxt; // reference two control
  word_t rd_nxt; // read data for the address phase
  word_t hrdata_r; // registered read data
  logic hreadyout_r; // always ready after reset
  logic wr_pend_r; // write data phase pending
  logic [7:0] wr_ofs_r; // offset of pending write
  half_t wr_lane_r; // byte lanes of pending write
  logic take; // address phase accepted

  logic [14:0] meta_r; // first synchroniser stage
  logic [14:0] sync_r; // second synchroniser stage
  logic [5:0] src_d_r; // delayed clock sources
  logic [5:0] src_rise; // source rising edges
  logic src_tick; // selected filter source tick
  logic mask_a_signal, mask_b_signal, mask_c_signal; // selected masks
  logic blank_and_output; // AND gate result
  logic blank; // OR gate result
  logic blanked; // comparator after blanking
  logic blank_r; // registered blank indication
  logic inv_ref2_r; // inverting input from reference two

  // ********************************************************
  // functions
  // ********************************************************
  // mask source decode, reserved codes give an idle mask
  function automatic logic pick_mask(input logic [3:0] sel,
                                     input logic [5:0] pwm,
                                     input logic [1:0] flt);
    logic r;
    r = 1'b0;
    case (sel)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: r = pwm[sel[2:0]];
      4'hE: r = flt[0];
      4'hF: r = flt[1];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pick_mask

  // byte lanes of the low half word touched by an access
  function automatic half_t lane_mask(input logic [2:0] sz, input logic [1:0] a);
    half_t m;
    m = 16'h0000;
    if (sz >= 3'h2) begin
      m = 16'hFFFF;
    end else if (sz == 3'h1) begin
      m = a[1] ? 16'h0000 : 16'hFFFF;
    end else begin
      m = (a == 2'h0) ? 16'h00FF : ((a == 2'h1) ? 16'hFF00 : 16'h0000);
    end
    return m;
  endfunction : lane_mask

  // merge written lanes into implemented bits only
  function automatic half_t merge(input half_t old, input half_t wd,
                                  input half_t lanes, input half_t impl);
    half_t w;
    w = lanes & impl;
    return (old & ~w) | (wd & w);
  endfunction : merge

  // ********************************************************
  // synchronisers
  // ********************************************************
  // every outside level passes two flops before any logic
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      meta_r <= 15'h0000;
      sync_r <= 15'h0000;
    end else begin
      meta_r <= {TIMER5_CLOCK, TIMER4_CLOCK, TIMER3_CLOCK, TIMER2_CLOCK,
                 PWM_SYNC_OUTPUT_ONE, OSC_CLOCK, FAULT_IN, PWM_IN, COMP_IN};
      sync_r <= meta_r;
    end
  end

  // delayed copy of the source clocks for edge detection
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      src_d_r <= 6'h00;
    end else begin
      src_d_r <= sync_r[14:9];
    end
  end

  // rising edge per source; sources faster than CLK/4 will alias
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_edge
      assign src_rise[gi] = sync_r[9 + gi] & ~src_d_r[gi];
    end
  endgenerate

  // ********************************************************
  // filter clock select
  // ********************************************************
  always_comb begin
    case (clk_src_e'(filt_r[6:4]))
      SRC_PERIPH: src_tick = 1'b1;
      SRC_OSC: src_tick = src_rise[0];
      SRC_PWM_SYNC: src_tick = src_rise[1];
      SRC_TIMER2: src_tick = src_rise[2];
      SRC_TIMER3: src_tick = src_rise[3];
      SRC_TIMER4: src_tick = src_rise[4];
      SRC_TIMER5: src_tick = src_rise[5];
      default: src_tick = 1'b0; // reserved code never samples
    endcase
  end

  // ********************************************************
  // blanking
  // ********************************************************
  assign mask_a_signal = pick_mask(mask_src_r[3:0], sync_r[6:1], sync_r[8:7]);
  assign mask_b_signal = pick_mask(mask_src_r[7:4], sync_r[6:1], sync_r[8:7]);
  assign mask_c_signal = pick_mask(mask_src_r[11:8], sync_r[6:1], sync_r[8:7]);

  // AND of enabled terms; no term enabled leaves the gate low
  always_comb begin
    blank_and_output = |gate_r[5:0];
    if (gate_r[`CMPF_BIT_AND_B_TRUE] && !mask_b_signal) begin
      blank_and_output = 1'b0;
    end
    if (gate_r[`CMPF_BIT_AND_B_INV] && mask_b_signal) begin
      blank_and_output = 1'b0;
    end
    if (gate_r[`CMPF_BIT_AND_A_TRUE] && !mask_a_signal) begin
      blank_and_output = 1'b0;
    end
    if (gate_r[`CMPF_BIT_AND_A_INV] && mask_a_signal) begin
      blank_and_output = 1'b0;
    end
    if (gate_r[5] && !mask_c_signal) begin
      blank_and_output = 1'b0;
    end
    if (gate_r[4] && mask_c_signal) begin
      blank_and_output = 1'b0;
    end
  end

  // OR of direct mask terms and the gated AND result
  assign blank = (gate_r[`CMPF_BIT_AND_TO_OR] && blank_and_output)
    || (gate_r[`CMPF_BIT_NAND_TO_OR] && !blank_and_output)
    || (gate_r[13] && mask_c_signal) || (gate_r[12] && !mask_c_signal)
    || (gate_r[11] && mask_b_signal) || (gate_r[10] && !mask_b_signal)
    || (gate_r[9] && mask_a_signal) || (gate_r[8] && !mask_a_signal);

  // suppress the asserted level chosen by the level select
  assign blanked = gate_r[`CMPF_BIT_LEVEL_SEL] ? (sync_r[0] | blank)
                                               : (sync_r[0] & ~blank);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      blank_r <= 1'b0;
    end else begin
      blank_r <= blank;
    end
  end

  // ********************************************************
  // filter
  // ********************************************************
  cmpf_filter_core u_filter (
    .clk(CLK),
    .rst_n(RST_N),
    .en(filt_r[`CMPF_BIT_FILT_EN]),
    .src_tick(src_tick),
    .div_code(filt_r[2:0]),
    .din(blanked),
    .dout(COMP_OUT)
  );

  // ********************************************************
  // bus address phase
  // ********************************************************
  assign take = HSEL && HREADY && HTRANS[1];

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 8'h00;
      wr_lane_r <= 16'h0000;
    end else begin
      wr_pend_r <= take && HWRITE;
      if (take) begin
        wr_ofs_r <= HADDR[7:0];
        wr_lane_r <= lane_mask(HSIZE, HADDR[1:0]);
      end
    end
  end

  // ********************************************************
  // register next values
  // ********************************************************
  always_comb begin
    mask_src_nxt = mask_src_r;
    gate_nxt = gate_r;
    filt_nxt = filt_r;
    ref1_nxt = ref1_r;
    ref2_nxt = ref2_r;
    if (wr_pend_r) begin
      case (wr_ofs_r)
        `CMPF_OFS_MASK_SRC: mask_src_nxt = merge(mask_src_r, HWDATA[15:0], wr_lane_r, `CMPF_IMPL_MASK_SRC);
        `CMPF_OFS_MASK_GATE: gate_nxt = merge(gate_r, HWDATA[15:0], wr_lane_r, `CMPF_IMPL_MASK_GATE);
        `CMPF_OFS_FILTER: filt_nxt = merge(filt_r, HWDATA[15:0], wr_lane_r, `CMPF_IMPL_FILTER);
        `CMPF_OFS_REF_ONE: ref1_nxt = merge(ref1_r, HWDATA[15:0], wr_lane_r, `CMPF_IMPL_REF);
        `CMPF_OFS_REF_TWO: ref2_nxt = merge(ref2_r, HWDATA[15:0], wr_lane_r, REF2_IMPL);
        default: mask_src_nxt = mask_src_r; // unmapped or read-only
      endcase
    end
  end

  // control registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mask_src_r <= `CMPF_RESET_VALUE;
      gate_r <= `CMPF_RESET_VALUE;
      filt_r <= `CMPF_RESET_VALUE;
      ref1_r <= `CMPF_RESET_VALUE;
      ref2_r <= `CMPF_RESET_VALUE;
    end else begin
      mask_src_r <= mask_src_nxt;
      gate_r <= gate_nxt;
      filt_r <= filt_nxt;
      ref1_r <= ref1_nxt;
      ref2_r <= ref2_nxt;
    end
  end

  // ********************************************************
  // read path
  // ********************************************************
  // reads use next values so a write just ahead is seen
  always_comb begin
    case (HADDR[7:0])
      `CMPF_OFS_MASK_SRC: rd_nxt = {16'h0000, mask_src_nxt};
      `CMPF_OFS_MASK_GATE: rd_nxt = {16'h0000, gate_nxt};
      `CMPF_OFS_FILTER: rd_nxt = {16'h0000, filt_nxt};
      `CMPF_OFS_REF_ONE: rd_nxt = {16'h0000, ref1_nxt};
      `CMPF_OFS_REF_TWO: rd_nxt = {16'h0000, ref2_nxt};
      `CMPF_OFS_STATUS: rd_nxt = {29'h00000000, COMP_OUT, blank_r, sync_r[0]};
      default: rd_nxt = 32'h00000000; // unmapped reads zero
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      hrdata_r <= 32'h00000000;
      hreadyout_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1; // zero wait states
      if (take && !HWRITE) begin
        hrdata_r <= rd_nxt;
      end
    end
  end

  assign HRDATA = hrdata_r;
  assign HREADYOUT = hreadyout_r;
  assign HRESP = 1'b0; // always OKAY

  // ********************************************************
  // reference outputs
  // ********************************************************
  // ladder selection is only meaningful with the ladder in use
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      inv_ref2_r <= 1'b0;
    end else begin
      inv_ref2_r <= !ref1_r[`CMPF_BIT_REF_INPUT] && ref2_r[`CMPF_BIT_REF_INPUT];
    end
  end

  assign REF1_POWER_ON = ref1_r[`CMPF_BIT_REF_POWER];
  assign REF1_PIN_OUTPUT_ENABLE = ref1_r[`CMPF_BIT_REF_PIN_OE];
  assign REF1_SUPPLY_SELECT = ref1_r[`CMPF_BIT_REF_SUPPLY];
  assign REF1_INPUT_SELECT = ref1_r[`CMPF_BIT_REF_INPUT];
  assign REF1_LEVEL_CODE = ref1_r[6:0];
  assign REF2_POWER_ON = ref2_r[`CMPF_BIT_REF_POWER];
  assign REF2_PIN_OUTPUT_ENABLE = ref2_r[`CMPF_BIT_REF_PIN_OE];
  assign REF2_SUPPLY_SELECT = ref2_r[`CMPF_BIT_REF_SUPPLY];
  assign REF2_LEVEL_CODE = ref2_r[6:0];
  assign INV_INPUT_FROM_REF_TWO = inv_ref2_r;
  assign BLANK_ACTIVE = blank_r;

  // ********************************************************
  // checks
  // ********************************************************
  AST_AND_B: assert property (
    @(posedge CLK) disable iff (!RST_N)
    gate_r[3] && !mask_b_signal |-> !blank_and_output)
    else $error("AND gate high with mask B term low");

  AST_AND_A: assert property (
    @(posedge CLK) disable iff (!RST_N)
    gate_r[0] && mask_a_signal |-> !blank_and_output)
    else $error("AND gate high with inverted mask A low");

  AST_PERIPH_TICK: assert property (
    @(posedge CLK) disable iff (!RST_N)
    filt_r[6:4] == 3'h0 |-> src_tick)
    else $error("peripheral clock source missed a tick");

  AST_RESERVED_SRC: assert property (
    @(posedge CLK) disable iff (!RST_N)
    filt_r[6:4] == 3'h3 |-> !src_tick)
    else $error("reserved filter source produced a tick");

  AST_REF_ZERO_BITS: assert property (
    @(posedge CLK) disable iff (!RST_N)
    ##1 ref1_r[13:12] == 2'h0 && ref1_r[9:7] == 3'h0 && ref2_r[13:12] == 2'h0 && ref2_r[9:7] == 3'h0)
    else $error("unimplemented reference bit set");

  AST_INV_SELECT: assert property (
    @(posedge CLK) disable iff (!RST_N)
    ref1_r[10] ##1 1'b1 |-> !INV_INPUT_FROM_REF_TWO)
    else $error("reference two chosen while external input selected");

  AST_BLANK_HIGH: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !gate_r[15] && blank |-> !blanked)
    else $error("high comparator level passed during blanking");

  AST_AND_TO_OR: assert property (
    @(posedge CLK) disable iff (!RST_N)
    gate_r[6] && blank_and_output |=> BLANK_ACTIVE)
    else $error("AND output did not reach OR gate");

  AST_PWR_WRITE: assert property (
    @(posedge CLK) disable iff (!RST_N)
    wr_pend_r && wr_ofs_r == 8'h0C && wr_lane_r[15] |=> REF1_POWER_ON == $past(HWDATA[15]))
    else $error("reference one power bit did not follow write");

endmodule : comparator_blank_filter_ref_ctrl

// ### sim/test_comparator_blank_filter_ref_ctrl.sv
// Purpose: self-checking bench for comparator blanking, filter and reference control
// Assumes: zero-wait AHB-Lite slave; filter source clocks are one slow toggle, gated per source
// Notes: only mismatches and the verdict are printed
`timescale 1ns/1ps
`include "cmpf_consts.svh"
module test_comparator_blank_filter_ref_ctrl;
  import cmpf_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, comp_in = 1'b0, clr = 1'b0, seen = 1'b0;
  logic [31:0] haddr = 32'h0; // byte address
  logic [1:0] htrans = 2'h0; // idle at start
  word_t hwdata = 32'h0, hrdata, q; // q holds the last read word
  logic [5:0] pwm = 6'h00; // mask sources
  logic [1:0] flt = 2'h0; // fault pins used as mask sources
  logic [5:0] son = 6'h3F; // which filter source clocks run
  logic [3:0] sdiv = 4'h0; // bit 2 is the slow source clock, period 8 cycles
  logic hrdyo, hresp, cout, blank, r1p, r1o, r1s, r1i, r2p, r2o, r2s, inv;
  level_t l1, l2; // reference level codes
  int miscompares = 0, total_checks = 0;
  // table of blanking cases: gating word, mask inputs, comparator level, expectations
  logic [15:0] gt [8] = '{16'h004A, 16'h004A, 16'h0049, 16'h0046, 16'h0088, 16'h804A, 16'h804A, 16'h000A};
  logic [1:0] pw [8] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h0, 2'h3, 2'h0, 2'h3};
  logic [7:0] ci = 8'h9F, eb = 8'h3D, eo = 8'hA2; // one bit per table row
  logic [2:0] sc [7] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7, 3'h3}; // reserved code last
  // only the source that the code names runs (all run for the reserved code), so a wrong pick never samples
  logic [5:0] so [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h3F};

  // ********************************************************
  // clocks and monitors
  // ********************************************************
  always #4 clk = ~clk;
  // free-running divider; slower than CLK/4 so the synchroniser sees every edge
  always @(posedge clk) sdiv <= sdiv + 4'h1;
  // sticky flag: did the filtered output go high since the last clear
  always @(posedge clk) seen <= clr ? 1'b0 : (seen | cout);

  comparator_blank_filter_ref_ctrl u_dut (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdyo), .HRDATA(hrdata),
    .HREADYOUT(hrdyo), .HRESP(hresp), .COMP_IN(comp_in), .PWM_IN(pwm), .FAULT_IN(flt),
    .OSC_CLOCK(sdiv[2] & son[0]), .PWM_SYNC_OUTPUT_ONE(sdiv[2] & son[1]), .TIMER2_CLOCK(sdiv[2] & son[2]),
    .TIMER3_CLOCK(sdiv[2] & son[3]), .TIMER4_CLOCK(sdiv[2] & son[4]), .TIMER5_CLOCK(sdiv[2] & son[5]),
    .COMP_OUT(cout), .BLANK_ACTIVE(blank),
    .REF1_POWER_ON(r1p), .REF1_PIN_OUTPUT_ENABLE(r1o), .REF1_SUPPLY_SELECT(r1s), .REF1_INPUT_SELECT(r1i),
    .REF1_LEVEL_CODE(l1), .REF2_POWER_ON(r2p), .REF2_PIN_OUTPUT_ENABLE(r2o), .REF2_SUPPLY_SELECT(r2s),
    .REF2_LEVEL_CODE(l2), .INV_INPUT_FROM_REF_TWO(inv));

  // ********************************************************
  // reporting and bus tasks
  // ********************************************************
  task test_done;
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task chk_word(input word_t got, input word_t exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // waits for a rising edge with ready high; a stuck slave ends the run
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdyo !== 1'b1 && n < 50);
    if (hrdyo !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t bus ready timeout", $time);
      test_done;
    end
  endtask : wait_rdy

  // one single word transfer; read data is taken at the data-phase edge
  task xfer(input logic w, input logic [7:0] a, input word_t d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask : xfer

  task rd(input logic [7:0] a, input word_t exp);
    xfer(1'b0, a, 32'h0);
    chk_word(q, exp);
    chk_bit(hresp, 1'b0);
  endtask : rd

  // drives a comparator high pulse and reports whether it got through
  task pulse(input int len, input int hold, input logic exp);
    clr <= 1'b1;
    comp_in <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (len - 1) @(posedge clk);
    comp_in <= 1'b0;
    repeat (hold) @(posedge clk);
    chk_bit(seen, exp);
  endtask : pulse

  // ********************************************************
  // main sequence
  // ********************************************************
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`CMPF_OFS_FILTER, 32'h0);
    rd(`CMPF_OFS_REF_ONE, 32'h0);
    rd(`CMPF_OFS_REF_TWO, 32'h0);
    rd(8'h40, 32'h0);
    // references: unimplemented bits and the upper half never stick
    xfer(1'b1, `CMPF_OFS_REF_TWO, 32'hFFFFFFFF);
    xfer(1'b1, `CMPF_OFS_REF_ONE, 32'h0000FFFF);
    rd(`CMPF_OFS_REF_TWO, 32'h0000CC7F);
    rd(`CMPF_OFS_REF_ONE, 32'h0000CC7F);
    repeat (2) @(posedge clk);
    chk_word({10'h0, r1p, r1o, r1s, r1i, l1, r2p, r2o, r2s, l2, inv}, 32'h3FFFFE);
    xfer(1'b1, `CMPF_OFS_REF_ONE, 32'h0);
    repeat (2) @(posedge clk);
    chk_word({10'h0, r1p, r1o, r1s, r1i, l1, r2p, r2o, r2s, l2, inv}, 32'h0007FF);
    xfer(1'b1, `CMPF_OFS_REF_TWO, 32'h00000055);
    rd(`CMPF_OFS_REF_TWO, 32'h00000055);
    repeat (2) @(posedge clk);
    chk_word({10'h0, r1p, r1o, r1s, r1i, l1, r2p, r2o, r2s, l2, inv}, 32'h0000AA);
    xfer(1'b1, `CMPF_OFS_FILTER, 32'h0000FFFF);
    rd(`CMPF_OFS_FILTER, 32'h0000007F);
    // blanking: mask A from the first PWM low output, mask B from its high output
    xfer(1'b1, `CMPF_OFS_FILTER, 32'h0);
    xfer(1'b1, `CMPF_OFS_MASK_SRC, 32'h00000010);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, `CMPF_OFS_MASK_GATE, {16'h0, gt[i]});
      pwm <= {4'h0, pw[i]};
      comp_in <= ci[i];
      repeat (6) @(posedge clk);
      chk_bit(blank, eb[i]);
      chk_bit(cout, eo[i]);
      rd(`CMPF_OFS_STATUS, {29'h0, eo[i], eb[i], ci[i]});
    end
    // fault pins as masks: A from the first fault pin, B from the second
    xfer(1'b1, `CMPF_OFS_MASK_SRC, 32'h000000FE);
    xfer(1'b1, `CMPF_OFS_MASK_GATE, 32'h0000004A);
    for (int i = 1; i < 4; i += 2) begin
      flt <= 2'(i);
      repeat (6) @(posedge clk);
      chk_bit(blank, i == 3);
    end
    xfer(1'b1, `CMPF_OFS_MASK_GATE, 32'h0);
    comp_in <= 1'b0;
    repeat (6) @(posedge clk);
    // filter on the bus clock: short glitches are eaten, long levels pass
    xfer(1'b1, `CMPF_OFS_FILTER, 32'h00000008);
    pulse(2, 12, 1'b0);
    pulse(6, 12, 1'b1);
    xfer(1'b1, `CMPF_OFS_FILTER, 32'h0000000A);
    pulse(6, 24, 1'b0);
    pulse(20, 24, 1'b1);
    xfer(1'b1, `CMPF_OFS_FILTER, 32'h0);
    pulse(1, 8, 1'b1);
    // every source clock input; the reserved code never samples
    for (int i = 0; i < 7; i++) begin
      son <= so[i];
      xfer(1'b1, `CMPF_OFS_FILTER, {25'h0, sc[i], 4'h8});
      pulse(60, 40, i < 6);
    end
    test_done;
  end
endmodule : test_comparator_blank_filter_ref_ctrl
